// *** suspend_ctrl.v ***
// Purpose: program/erase suspend and resume control with command gating
// Assumes: array engine reports the running operation and its sector/page
// Notes: data bytes after suspend/resume opcodes are never examined
`timescale 1ns/1ps
`include "susp_map.vh"
module suspend_ctrl #(
  parameter SUSP_CYC = `SUSP_LAT_CYC,
  parameter RES_CYC  = `RES_LAT_CYC
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       sck,
  input  wire       cs_n,
  input  wire       mosi,
  input  wire       op_busy,
  input  wire [1:0] op_kind,
  input  wire [5:0] op_sector,
  input  wire [12:0] op_page,
  input  wire       op_page_level,
  input  wire       cmd_valid,
  input  wire [3:0] cmd_class,
  input  wire [5:0] cmd_sector,
  input  wire       rd_active,
  input  wire [5:0] rd_sector,
  input  wire       reset_req,
  output reg        op_halt,
  output reg        op_resume,
  output reg        op_abort,
  output reg        cmd_accept,
  output reg        cmd_reject,
  output reg        prog_abort,
  output reg        rd_undef,
  output reg        undef_sector,
  output reg        undef_page,
  output reg [5:0]  undef_sector_num,
  output reg [12:0] undef_page_num,
  output reg        prog_suspend_buf_one_flag,
  output reg        prog_suspend_buf_two_flag,
  output reg        erase_suspend_flag,
  output reg        ready
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SUSP = 2'h1;
  localparam ST_RES  = 2'h2;
  wire [7:0] rx_byte;
  wire       byte_first;
  wire       byte_valid;
  wire       cs_rise;
  reg  [1:0] st_q;
  reg        got_susp_q;
  reg        got_res_q;
  reg [15:0] cnt_q;
  reg  [5:0] es_sec_q;
  reg  [5:0] ps_sec_q;
  reg [12:0] es_page_q;
  reg [12:0] ps_page_q;
  reg        es_pg_q;
  reg        ps_pg_q;
  reg        allowed;
  wire       ps_any = prog_suspend_buf_one_flag | prog_suspend_buf_two_flag;
  wire       any_susp = ps_any | erase_suspend_flag;
  spi_rx u_rx (
    .clk        (clk),
    .rst        (rst),
    .sck        (sck),
    .cs_n       (cs_n),
    .mosi       (mosi),
    .rx_byte    (rx_byte),
    .byte_first (byte_first),
    .byte_valid (byte_valid),
    .cs_rise    (cs_rise)
  );
  // True where a sector holds a suspended operation
  function hit;
    input [5:0] s;
    begin
      hit = (erase_suspend_flag & (s == es_sec_q)) |
            (ps_any & (s == ps_sec_q));
    end
  endfunction
  // Gating table for commands while suspended
  always @* begin
    allowed = 1'b1;
    if (any_susp) begin
      case (cmd_class)
        `CL_READ:      allowed = 1'b1;
        `CL_BUF1_WR,
        `CL_BUF1_CMP:  allowed = ~prog_suspend_buf_one_flag;
        `CL_BUF2_WR,
        `CL_BUF2_CMP:  allowed = ~prog_suspend_buf_two_flag;
        `CL_PROG_NOER: allowed = ~ps_any;
        `CL_PROG_ERASE,
        `CL_ERASE:     allowed = 1'b0;
        `CL_PROTECT:   allowed = 1'b0;
        `CL_PROT_READ: allowed = 1'b1;
        `CL_POWERDOWN: allowed = 1'b0;
        `CL_INFO_READ,
        `CL_RESET:     allowed = 1'b1;
        default:       allowed = 1'b1;
      endcase
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE; got_susp_q <= 1'b0; got_res_q <= 1'b0;
      cnt_q <= 16'h0000; es_sec_q <= 6'h00; ps_sec_q <= 6'h00;
      es_page_q <= 13'h0000; ps_page_q <= 13'h0000;
      es_pg_q <= 1'b0; ps_pg_q <= 1'b0;
      op_halt <= 1'b0; op_resume <= 1'b0; op_abort <= 1'b0;
      cmd_accept <= 1'b0; cmd_reject <= 1'b0; prog_abort <= 1'b0;
      rd_undef <= 1'b0; undef_sector <= 1'b0; undef_page <= 1'b0;
      undef_sector_num <= 6'h00; undef_page_num <= 13'h0000;
      prog_suspend_buf_one_flag <= 1'b0;
      prog_suspend_buf_two_flag <= 1'b0;
      erase_suspend_flag <= 1'b0;
      ready <= 1'b1;
    end else begin
      op_halt <= 1'b0; op_resume <= 1'b0; op_abort <= 1'b0;
      cmd_accept <= 1'b0; cmd_reject <= 1'b0; prog_abort <= 1'b0;
      undef_sector <= 1'b0; undef_page <= 1'b0;
      // Undefined output for the whole span of a suspended sector
      rd_undef <= rd_active & hit(rd_sector);
      // Only the opcode byte is decoded; later bytes are dropped
      if (byte_valid & byte_first) begin
        got_susp_q <= (rx_byte == `OP_SUSPEND);
        got_res_q  <= (rx_byte == `OP_RESUME);
      end
      if (cs_rise) begin
        got_susp_q <= 1'b0;
        got_res_q  <= 1'b0;
      end
      if (cmd_valid) begin
        if (!allowed) begin
          cmd_reject <= 1'b1;
        end else if ((cmd_class == `CL_PROG_NOER) & erase_suspend_flag &
                     (cmd_sector == es_sec_q)) begin
          prog_abort <= 1'b1;
        end else begin
          cmd_accept <= 1'b1;
        end
      end
      if (reset_req) begin
        // Reset drops every suspend; erase damage reported by its scope (page or sector); with no erase held, a program suspend always as a page
        if (erase_suspend_flag) begin
          if (es_pg_q) begin
            undef_page <= 1'b1;
            undef_page_num <= es_page_q;
          end else begin
            undef_sector <= 1'b1;
            undef_sector_num <= es_sec_q;
          end
        end else if (ps_any) begin
          undef_page <= 1'b1;
          undef_page_num <= ps_page_q;
        end
        op_abort <= any_susp;
        prog_suspend_buf_one_flag <= 1'b0;
        prog_suspend_buf_two_flag <= 1'b0;
        erase_suspend_flag <= 1'b0;
        st_q <= ST_IDLE;
        ready <= 1'b1;
      end else begin
        case (st_q)
          ST_IDLE: begin
            ready <= ~op_busy;
            if (cs_rise & got_susp_q & op_busy) begin
              op_halt <= 1'b1;
              cnt_q <= 16'h0000;
              st_q <= ST_SUSP;
            end else if (cs_rise & got_res_q & any_susp) begin
              op_resume <= 1'b1;
              ready <= 1'b0;
              cnt_q <= 16'h0000;
              // Program resumes ahead of a held erase
              if (ps_any) begin
                prog_suspend_buf_one_flag <= 1'b0;
                prog_suspend_buf_two_flag <= 1'b0;
              end else begin
                erase_suspend_flag <= 1'b0;
              end
              st_q <= ST_RES;
            end
          end
          ST_SUSP: begin
            cnt_q <= cnt_q + 16'h0001;
            // Flags and ready show only after the latency window
            if (cnt_q == SUSP_CYC[15:0]) begin
              case (op_kind)
                `OPK_PROG1: prog_suspend_buf_one_flag <= 1'b1;
                `OPK_PROG2: prog_suspend_buf_two_flag <= 1'b1;
                `OPK_ERASE: erase_suspend_flag <= 1'b1;
                default:    prog_suspend_buf_one_flag <= 1'b0;
              endcase
              if (op_kind == `OPK_ERASE) begin
                es_sec_q <= op_sector;
                es_page_q <= op_page;
                es_pg_q <= op_page_level;
              end else begin
                ps_sec_q <= op_sector;
                ps_page_q <= op_page;
                ps_pg_q <= op_page_level;
              end
              ready <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
          ST_RES: begin
            // Suspend opcodes are dropped for the whole resume window
            ready <= 1'b0;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == RES_CYC[15:0]) begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // suspend_ctrl

// *** susp_map.vh ***
// Purpose: constants for the program/erase suspend controller
// Assumes: opcode classes are decoded outside and arrive as a class code
// Notes: suspend opcode B0h, resume opcode D0h
`ifndef SUSP_MAP_VH
`define SUSP_MAP_VH
`define OP_SUSPEND     8'hb0
`define OP_RESUME      8'hd0
`define SUSP_LAT_NS    20000
`define RES_LAT_NS     20000
`define CLK_NS         40
`define SUSP_LAT_CYC   (`SUSP_LAT_NS / `CLK_NS)
`define RES_LAT_CYC    (`RES_LAT_NS / `CLK_NS)
// Command classes presented on cmd_class
`define CL_READ        4'h0
`define CL_BUF1_WR     4'h1
`define CL_BUF2_WR     4'h2
`define CL_BUF1_CMP    4'h3
`define CL_BUF2_CMP    4'h4
`define CL_PROG_NOER   4'h5
`define CL_PROG_ERASE  4'h6
`define CL_PROTECT     4'h7
`define CL_PROT_READ   4'h8
`define CL_POWERDOWN   4'h9
`define CL_INFO_READ   4'ha
`define CL_RESET       4'hb
`define CL_ERASE       4'hc
// Kind of operation running
`define OPK_PROG1      2'h1
`define OPK_PROG2      2'h2
`define OPK_ERASE      2'h3
`endif

// *** spi_rx.v ***
// Purpose: SPI mode 0 byte receiver sampled by the system clock
// Assumes: sck well below clk/4
// Notes: pins pass two flops before use
`timescale 1ns/1ps
module spi_rx (
  input  wire       clk,
  input  wire       rst,
  input  wire       sck,
  input  wire       cs_n,
  input  wire       mosi,
  output reg  [7:0] rx_byte,
  output reg        byte_first,
  output reg        byte_valid,
  output reg        cs_rise
);
  reg [1:0] sck_s;
  reg [1:0] cs_s;
  reg [1:0] mo_s;
  reg       sck_p;
  reg       cs_p;
  reg [2:0] cnt;
  reg [6:0] sh;
  reg       first;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s <= 2'h0; cs_s <= 2'h3; mo_s <= 2'h0;
      sck_p <= 1'b0; cs_p <= 1'b1; cnt <= 3'h0; sh <= 7'h00;
      first <= 1'b1; rx_byte <= 8'h00; byte_first <= 1'b0;
      byte_valid <= 1'b0; cs_rise <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], sck};
      cs_s  <= {cs_s[0], cs_n};
      mo_s  <= {mo_s[0], mosi};
      sck_p <= sck_s[1];
      cs_p  <= cs_s[1];
      byte_valid <= 1'b0;
      cs_rise <= cs_s[1] & ~cs_p;
      if (cs_s[1]) begin
        cnt <= 3'h0;
        first <= 1'b1;
      end else if (sck_s[1] & ~sck_p) begin
        cnt <= cnt + 3'h1;
        sh <= {sh[5:0], mo_s[1]};
        if (cnt == 3'h7) begin
          rx_byte <= {sh, mo_s[1]};
          byte_valid <= 1'b1;
          byte_first <= first;
          first <= 1'b0;
        end
      end
    end
  end
endmodule // spi_rx

// *** suspend_ctrl_sva.sv ***
// Purpose: port checker for suspend_ctrl
// Assumes: SUSP_CYC is the shortened sim value
// Notes: single clock domain, so default clocking
`timescale 1ns/1ps
`include "susp_map.vh"
module suspend_ctrl_sva #(
  parameter int SUSP_CYC = 8
) (
  input logic       clk,
  input logic       rst,
  input logic       cmd_valid,
  input logic [3:0] cmd_class,
  input logic       reset_req,
  input logic       op_halt,
  input logic       op_resume,
  input logic       cmd_accept,
  input logic       cmd_reject,
  input logic       prog_abort,
  input logic       ready,
  input logic       prog_suspend_buf_one_flag,
  input logic       prog_suspend_buf_two_flag,
  input logic       erase_suspend_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  localparam int SW = SUSP_CYC + 1;
  wire p1 = prog_suspend_buf_one_flag;
  wire p2 = prog_suspend_buf_two_flag;
  wire anyf = p1 | p2 | erase_suspend_flag;
  sequence halt_s; op_halt; endsequence
  sequence held_s; ##SW ready && anyf; endsequence
  halt_sets_flag_a: assert property (halt_s |-> held_s)
    else $error("no flag or ready after halt");
  // Every command is answered next cycle by exactly one of accept, reject or abort pulse
  one_answer_a: assert property (cmd_valid |=>
    $onehot({cmd_accept, cmd_reject, prog_abort}))
    else $error("command not answered once");
  reads_kept_a: assert property (cmd_valid && anyf && cmd_class inside
    {`CL_READ, `CL_PROT_READ, `CL_INFO_READ} |=> cmd_accept)
    else $error("read refused in suspend");
  forbid_all_a: assert property (cmd_valid && anyf && cmd_class inside
    {`CL_PROG_ERASE, `CL_ERASE, `CL_PROTECT, `CL_POWERDOWN} |=> cmd_reject)
    else $error("forbidden command taken");
  buf_lock_a: assert property (cmd_valid && (p1 && cmd_class inside {1, 3}
    || p2 && cmd_class inside {2, 4}) |=> cmd_reject)
    else $error("suspended buffer used");
  no_erase_prog_a: assert property (cmd_valid && cmd_class == `CL_PROG_NOER
    && (p1 || p2) |=> cmd_reject)
    else $error("program taken in program suspend");
  reject_quiet_a: assert property (cmd_reject |-> $stable({p1, p2, anyf}))
    else $error("flags moved on rejection");
  resume_busy_a: assert property (op_resume |-> !ready)
    else $error("ready during resume");
  reset_clear_a: assert property (reset_req |=> !anyf)
    else $error("flags kept over reset");
endmodule // suspend_ctrl_sva
bind suspend_ctrl suspend_ctrl_sva #(.SUSP_CYC(SUSP_CYC)) suspend_ctrl_sva_i (.*);

// *** spi_host.sv ***
// Purpose: SPI mode 0 host that sends one command frame
// Assumes: 320 ns serial clock
// Notes: sck idles low between frames
`timescale 1ns/1ps
module spi_host (
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sck = 0;
    cs_n = 1;
    mosi = 0;
  end
  // Opcode first, then filler bytes the device must not decode
  task automatic frame(input logic [7:0] op, input int extra);
    #7 cs_n = 0;
    for (int b = 0; b < 8 * (1 + extra); b++) begin
      mosi = (b < 8) ? op[7 - b] : b[0];
      #160 sck = 1;
      #160 sck = 0;
    end
    #160 cs_n = 1;
    mosi = ~mosi; // Released line must not keep its last value
  endtask
endmodule // spi_host

// *** program_erase_suspend_control_tb_top.sv ***
// Purpose: bench for suspend_ctrl
// Assumes: latencies shortened by parameter
// Notes: resume kept long so a suspend can land inside it
`timescale 1ns/1ps
`include "susp_map.vh"
module program_erase_suspend_control_tb_top;
  localparam int SC = 8;
  logic        clk = 0, rst = 1, op_busy = 0, op_page_level = 0;
  logic        cmd_valid = 0, rd_active = 0, reset_req = 0, hit;
  logic        sck, cs_n, mosi, op_halt, op_resume, op_abort, ready;
  logic        cmd_accept, cmd_reject, prog_abort, rd_undef;
  logic        undef_sector, undef_page, prog_suspend_buf_one_flag;
  logic        prog_suspend_buf_two_flag, erase_suspend_flag;
  logic [1:0]  op_kind = 0;
  logic [3:0]  cmd_class = 0;
  logic [5:0]  op_sector = 0, cmd_sector = 0, rd_sector = 0, undef_sector_num;
  logic [12:0] op_page = 0, undef_page_num;
  int          n_errors = 0, n_checks = 0;
  always #20 clk = ~clk;
  spi_host spi_host_i (.sck(sck), .cs_n(cs_n), .mosi(mosi));
  suspend_ctrl #(.SUSP_CYC(SC), .RES_CYC(200)) suspend_ctrl_i (.*);
  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic await(int w, output logic h);
    h = 0;
    repeat (30) begin
      tick();
      if ((w == 0 ? op_halt : op_resume) === 1'b1) begin
        h = 1;
        break;
      end
    end
  endtask
  task automatic suspend(logic [1:0] k, logic [5:0] s);
    op_busy = 1;
    op_kind = k;
    op_sector = s;
    spi_host_i.frame(`OP_SUSPEND, 1);
    await(0, hit);
    chk("op_halt", 1, hit);
    tick(SC + 1);
    chk("ready", 1, ready);
    op_busy = 0;
  endtask
  // Codes follow the CL_ list; reset class left out as it ends suspend
  task automatic gate(logic p1, logic p2);
    logic e;
    for (int c = 0; c < 13; c++) begin
      if (c == 11) continue;
      e = c inside {0, 8, 10} || c inside {1, 3} && !p1 ||
          c inside {2, 4} && !p2 || c == 5 && !p1 && !p2;
      cmd_class = c[3:0];
      cmd_sector = 20;
      cmd_valid = 1;
      tick();
      chk("cmd_accept", e, cmd_accept);
      chk("cmd_reject", !e, cmd_reject);
    end
    cmd_valid = 0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    summarize();
  end
  initial begin
    tick(10);
    rst = 0;
    suspend(`OPK_ERASE, 5);
    chk("es", 1, erase_suspend_flag);
    gate(0, 0);
    chk("es", 1, erase_suspend_flag);
    cmd_class = `CL_PROG_NOER;
    cmd_sector = 5;
    cmd_valid = 1;
    tick();
    cmd_valid = 0;
    chk("prog_abort", 1, prog_abort);
    rd_active = 1;
    rd_sector = 5;
    tick(2);
    chk("rd_undef", 1, rd_undef);
    rd_sector = 6;
    tick(2);
    chk("rd_undef", 0, rd_undef);
    rd_active = 0;
    suspend(`OPK_PROG1, 9);
    chk("es_ps1", 3, {erase_suspend_flag, prog_suspend_buf_one_flag});
    gate(1, 0);
    spi_host_i.frame(`OP_RESUME, 0);
    await(1, hit);
    chk("op_resume", 1, hit);
    chk("es_ps1_rdy", 4, {erase_suspend_flag, prog_suspend_buf_one_flag, ready});
    op_busy = 1;
    spi_host_i.frame(`OP_SUSPEND, 0);
    await(0, hit);
    chk("op_halt", 0, hit);
    reset_req = 1;
    tick();
    reset_req = 0;
    chk("undef_sector", 1, undef_sector);
    chk("undef_sector_num", 5, undef_sector_num);
    chk("op_abort", 1, op_abort);
    tick();
    chk("es", 0, erase_suspend_flag);
    op_page_level = 1;
    op_page = 77;
    suspend(`OPK_PROG2, 12);
    chk("ps2", 1, prog_suspend_buf_two_flag);
    gate(0, 1);
    reset_req = 1;
    tick();
    reset_req = 0;
    chk("undef_page", 1, undef_page);
    chk("undef_page_num", 77, undef_page_num);
    chk("undef_sector", 0, undef_sector);
    summarize();
  end
endmodule // program_erase_suspend_control_tb_top
